// file: common/imm_decode_pkg.sv
// Opcode patterns, reset values and shared types of the immediate-load decoder.
package imm_decode_pkg;

  localparam int INSTR_WIDTH = 10;
  localparam int NIBBLE_WIDTH = 4;
  localparam int BANK_WIDTH = 2;

  // Opcode patterns and the masks that select their fixed bits.
  localparam logic [9:0] NOP_PATTERN = 10'h000;
  localparam logic [9:0] NOP_MASK = 10'h3ff;
  localparam logic [9:0] LOAD_ACC_PATTERN = 10'h070;
  localparam logic [9:0] LOAD_ACC_MASK = 10'h3f0;
  localparam logic [9:0] LOAD_PAIR_PATTERN = 10'h300;
  localparam logic [9:0] LOAD_PAIR_MASK = 10'h300;
  localparam logic [9:0] LOAD_BANK_PATTERN = 10'h048;
  localparam logic [9:0] LOAD_BANK_MASK = 10'h3fc;

  // Positions of the immediate fields.
  localparam int ACC_IMM_LSB = 0;
  localparam int PAIR_Y_LSB = 0;
  localparam int PAIR_X_LSB = 4;
  localparam int BANK_IMM_LSB = 0;

  // Reset values of the architectural registers.
  localparam logic [3:0] ACC_RESET = 4'h0;
  localparam logic [3:0] PTR_X_RESET = 4'h0;
  localparam logic [3:0] PTR_Y_RESET = 4'h0;
  localparam logic [1:0] BANK_RESET = 2'h0;
  localparam logic CARRY_RESET = 1'b0;

  typedef enum logic [2:0] {
    KIND_NOP,
    KIND_LOAD_ACC,
    KIND_LOAD_PAIR,
    KIND_LOAD_BANK,
    KIND_FOREIGN
  } instr_kind_t;

  // True when the fixed bits of an instruction word equal a pattern.
  function automatic logic op_match(input logic [9:0] word,
                                    input logic [9:0] pattern,
                                    input logic [9:0] mask);
    return (word & mask) == pattern;
  endfunction

endpackage

// file: common/decode_if.sv
// Interface that carries an instruction word to the classifier and back.
`timescale 1ns/10ps
interface decode_if;
  logic [9:0] instr;
  imm_decode_pkg::instr_kind_t kind;
  logic [3:0] imm_acc;
  logic [3:0] imm_x;
  logic [3:0] imm_y;
  logic [1:0] imm_bank;

  modport classifier (
    input instr,
    output kind,
    output imm_acc,
    output imm_x,
    output imm_y,
    output imm_bank
  );

  modport core (
    output instr,
    input kind,
    input imm_acc,
    input imm_x,
    input imm_y,
    input imm_bank
  );
endinterface

// file: core/opcode_classifier.sv
// Combinational classifier of immediate-load and no-operation opcodes.
`timescale 1ns/10ps
module opcode_classifier (
  // Instruction word in, decoded kind and fields out
  decode_if.classifier dec
);

  always_comb begin
    if (imm_decode_pkg::op_match(dec.instr, imm_decode_pkg::NOP_PATTERN,
                                 imm_decode_pkg::NOP_MASK)) begin
      dec.kind = imm_decode_pkg::KIND_NOP; // RULE6
    end else if (imm_decode_pkg::op_match(dec.instr,
                 imm_decode_pkg::LOAD_ACC_PATTERN,
                 imm_decode_pkg::LOAD_ACC_MASK)) begin
      dec.kind = imm_decode_pkg::KIND_LOAD_ACC; // RULE1
    end else if (imm_decode_pkg::op_match(dec.instr,
                 imm_decode_pkg::LOAD_PAIR_PATTERN,
                 imm_decode_pkg::LOAD_PAIR_MASK)) begin
      dec.kind = imm_decode_pkg::KIND_LOAD_PAIR; // RULE3
    end else if (imm_decode_pkg::op_match(dec.instr,
                 imm_decode_pkg::LOAD_BANK_PATTERN,
                 imm_decode_pkg::LOAD_BANK_MASK)) begin
      dec.kind = imm_decode_pkg::KIND_LOAD_BANK; // RULE5
    end else begin
      dec.kind = imm_decode_pkg::KIND_FOREIGN;
    end
  end

  assign dec.imm_acc = dec.instr[imm_decode_pkg::ACC_IMM_LSB +: 4];
  assign dec.imm_x = dec.instr[imm_decode_pkg::PAIR_X_LSB +: 4];
  assign dec.imm_y = dec.instr[imm_decode_pkg::PAIR_Y_LSB +: 4];
  assign dec.imm_bank = dec.instr[imm_decode_pkg::BANK_IMM_LSB +: 2];

endmodule

// file: core/immediate_load_nop_decoder.sv
// Execute logic for immediate loads and the no-operation instruction.
// Function
// [RULE1] Accumulator load writes 4-bit immediate, carry untouched.
// [RULE2] Only first of consecutive accumulator loads executes.
// [RULE3] Pair load sets both RAM pointers together.
// [RULE4] Only first of consecutive pair loads executes.
// [RULE5] Bank load writes 2-bit immediate to bank.
// [RULE6] All-zero opcode only increments program counter.
// [RULE7] Skipped load takes one cycle, advances counter.
`timescale 1ns/10ps
module immediate_load_nop_decoder #(
  parameter int PC_WIDTH = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Instruction fetch
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  // Carry write from the arithmetic unit
  input wire logic carry_we,
  input wire logic carry_din,
  // Architectural registers
  output logic [3:0] acc,
  output logic [3:0] ptr_x,
  output logic [3:0] ptr_y,
  output logic [1:0] bank_ptr,
  output logic carry_flag,
  output logic [PC_WIDTH-1:0] pc,
  // Per-instruction status pulses
  output logic retired,
  output logic skipped,
  output logic foreign
);

  decode_if dec ();

  opcode_classifier u_classifier (
    .dec(dec)
  );

  assign dec.instr = instr_word;

  logic [3:0] acc_reg;
  logic [3:0] acc_next;
  logic [3:0] ptr_x_reg;
  logic [3:0] ptr_x_next;
  logic [3:0] ptr_y_reg;
  logic [3:0] ptr_y_next;
  logic [1:0] bank_reg;
  logic [1:0] bank_next;
  logic carry_reg;
  logic carry_next;
  logic [PC_WIDTH-1:0] pc_reg;
  logic [PC_WIDTH-1:0] pc_next;
  logic retired_reg;
  logic retired_next;
  logic skipped_reg;
  logic skipped_next;
  logic foreign_reg;
  logic foreign_next;
  imm_decode_pkg::instr_kind_t last_kind_reg;
  imm_decode_pkg::instr_kind_t last_kind_next;
  logic skip_now;

  // An accumulator or pair load repeats the one just before it in program order.
  always_comb begin
    skip_now = 1'b0;
    if (instr_valid) begin
      case (dec.kind)
        imm_decode_pkg::KIND_LOAD_ACC: begin
          skip_now = last_kind_reg == imm_decode_pkg::KIND_LOAD_ACC; // RULE2
        end
        imm_decode_pkg::KIND_LOAD_PAIR: begin
          skip_now = last_kind_reg == imm_decode_pkg::KIND_LOAD_PAIR; // RULE4
        end
        default: begin
          skip_now = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    acc_next = acc_reg;
    ptr_x_next = ptr_x_reg;
    ptr_y_next = ptr_y_reg;
    bank_next = bank_reg;
    carry_next = carry_we ? carry_din : carry_reg; // RULE1
    pc_next = pc_reg;
    retired_next = 1'b0;
    skipped_next = 1'b0;
    foreign_next = 1'b0;
    last_kind_next = last_kind_reg;
    if (instr_valid) begin
      last_kind_next = dec.kind;
      if (dec.kind == imm_decode_pkg::KIND_FOREIGN) begin
        foreign_next = 1'b1;
      end else begin
        pc_next = pc_reg + 1'b1; // RULE6 RULE7
        retired_next = 1'b1;
        skipped_next = skip_now; // RULE7
        if (!skip_now) begin
          case (dec.kind)
            imm_decode_pkg::KIND_LOAD_ACC: begin
              acc_next = dec.imm_acc; // RULE1
            end
            imm_decode_pkg::KIND_LOAD_PAIR: begin
              ptr_x_next = dec.imm_x; // RULE3
              ptr_y_next = dec.imm_y; // RULE3
            end
            imm_decode_pkg::KIND_LOAD_BANK: begin
              bank_next = dec.imm_bank; // RULE5
            end
            default: begin
              acc_next = acc_reg;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= imm_decode_pkg::ACC_RESET;
      ptr_x_reg <= imm_decode_pkg::PTR_X_RESET;
      ptr_y_reg <= imm_decode_pkg::PTR_Y_RESET;
      bank_reg <= imm_decode_pkg::BANK_RESET;
      carry_reg <= imm_decode_pkg::CARRY_RESET;
      pc_reg <= '0;
      retired_reg <= 1'b0;
      skipped_reg <= 1'b0;
      foreign_reg <= 1'b0;
      last_kind_reg <= imm_decode_pkg::KIND_NOP;
    end else begin
      acc_reg <= acc_next;
      ptr_x_reg <= ptr_x_next;
      ptr_y_reg <= ptr_y_next;
      bank_reg <= bank_next;
      carry_reg <= carry_next;
      pc_reg <= pc_next;
      retired_reg <= retired_next;
      skipped_reg <= skipped_next;
      foreign_reg <= foreign_next;
      last_kind_reg <= last_kind_next;
    end
  end

  assign acc = acc_reg;
  assign ptr_x = ptr_x_reg;
  assign ptr_y = ptr_y_reg;
  assign bank_ptr = bank_reg;
  assign carry_flag = carry_reg;
  assign pc = pc_reg;
  assign retired = retired_reg;
  assign skipped = skipped_reg;
  assign foreign = foreign_reg;

  // Checks on the executed and skipped instruction effects.
  a_acc_load_value: // RULE1
  assert property (@(posedge clk) disable iff (!nrst)
    instr_valid && dec.kind == imm_decode_pkg::KIND_LOAD_ACC && !skip_now
    |=> acc_reg == $past(instr_word[3:0]) && retired_reg && !skipped_reg)
  else $error("accumulator load did not write the immediate");

  a_acc_load_carry: // RULE1
  assert property (@(posedge clk) disable iff (!nrst)
    instr_valid && dec.kind == imm_decode_pkg::KIND_LOAD_ACC && !carry_we
    |=> $stable(carry_reg))
  else $error("accumulator load changed the carry flag");

  a_acc_repeat_skip: // RULE2
  assert property (@(posedge clk) disable iff (!nrst)
    instr_valid && dec.kind == imm_decode_pkg::KIND_LOAD_ACC
    ##1 instr_valid && dec.kind == imm_decode_pkg::KIND_LOAD_ACC
    |=> $stable(acc_reg) && skipped_reg)
  else $error("repeated accumulator load was not skipped");

  a_pair_load_value: // RULE3
  assert property (@(posedge clk) disable iff (!nrst)
    instr_valid && dec.kind == imm_decode_pkg::KIND_LOAD_PAIR && !skip_now
    |=> ptr_x_reg == $past(instr_word[7:4])
        && ptr_y_reg == $past(instr_word[3:0]))
  else $error("pair load did not set both pointers");

  a_pair_repeat_skip: // RULE4
  assert property (@(posedge clk) disable iff (!nrst)
    instr_valid && dec.kind == imm_decode_pkg::KIND_LOAD_PAIR
    ##1 instr_valid && dec.kind == imm_decode_pkg::KIND_LOAD_PAIR
    |=> $stable(ptr_x_reg) && $stable(ptr_y_reg) && skipped_reg)
  else $error("repeated pair load was not skipped");

  a_pair_gap_skip: // RULE4
  assert property (@(posedge clk) disable iff (!nrst)
    instr_valid && dec.kind == imm_decode_pkg::KIND_LOAD_PAIR
    ##1 !instr_valid
    ##1 instr_valid && dec.kind == imm_decode_pkg::KIND_LOAD_PAIR
    |=> $stable(ptr_x_reg) && $stable(ptr_y_reg) && skipped_reg)
  else $error("pair load after an idle cycle was not skipped");

  a_bank_load_value: // RULE5
  assert property (@(posedge clk) disable iff (!nrst)
    instr_valid && dec.kind == imm_decode_pkg::KIND_LOAD_BANK
    |=> bank_reg == $past(instr_word[1:0]) && $stable(acc_reg))
  else $error("bank load did not write the immediate");

  a_nop_only_pc: // RULE6
  assert property (@(posedge clk) disable iff (!nrst)
    instr_valid && instr_word == imm_decode_pkg::NOP_PATTERN
    |=> pc_reg == PC_WIDTH'($past(pc_reg) + 1'b1) && $stable(acc_reg)
        && $stable(ptr_x_reg) && $stable(ptr_y_reg) && $stable(bank_reg))
  else $error("no-operation changed more than the counter");

  a_skip_advances_pc: // RULE7
  assert property (@(posedge clk) disable iff (!nrst)
    skip_now |=> skipped_reg && retired_reg
    && pc_reg == PC_WIDTH'($past(pc_reg) + 1'b1)
    ##1 (!skipped_reg || $past(skip_now)))
  else $error("skipped load did not take one cycle");

endmodule

// file: verif/immediate_load_nop_decoder_tb.sv
// Self-checking testbench of the immediate-load and no-operation decoder.
`timescale 1ns/10ps
module immediate_load_nop_decoder_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  logic [9:0] instr_word = 10'h000;
  logic carry_we = 1'b0;
  logic carry_din = 1'b0;
  logic [3:0] acc;
  logic [3:0] ptr_x;
  logic [3:0] ptr_y;
  logic [1:0] bank_ptr;
  logic carry_flag;
  logic [11:0] pc;
  logic retired;
  logic skipped;
  logic foreign;
  logic [11:0] e_pc = 12'h000;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;

  immediate_load_nop_decoder #(.PC_WIDTH(12)) DUT (
    .clk(clk),
    .nrst(nrst),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .carry_we(carry_we),
    .carry_din(carry_din),
    .acc(acc),
    .ptr_x(ptr_x),
    .ptr_y(ptr_y),
    .bank_ptr(bank_ptr),
    .carry_flag(carry_flag),
    .pc(pc),
    .retired(retired),
    .skipped(skipped),
    .foreign(foreign)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total = err_total + 1;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Compares the state left by the instruction taken at the last edge.
  task automatic st(input logic [3:0] a, input logic [3:0] x,
                    input logic [3:0] y, input logic [1:0] z,
                    input logic r, input logic s, input logic f);
    if (r) begin
      e_pc = e_pc + 12'h001;
    end
    chk({acc, ptr_x, ptr_y, 2'b00, bank_ptr}, {a, x, y, 2'b00, z});
    chk({4'h0, pc}, {4'h0, e_pc});
    chk({13'h0000, retired, skipped, foreign}, {13'h0000, r, s, f});
  endtask

  // Presents one word; the outputs seen on return belong to the prior call.
  task automatic go(input logic v, input logic [9:0] w);
    @(posedge clk);
    instr_valid <= v;
    instr_word <= w;
    @(negedge clk);
  endtask

  task automatic t_acc();
    go(1'b1, 10'h075);
    go(1'b1, 10'h07a);
    st(4'h5, 4'h0, 4'h0, 2'h0, 1'b1, 1'b0, 1'b0);
    go(1'b1, 10'h07f);
    st(4'h5, 4'h0, 4'h0, 2'h0, 1'b1, 1'b1, 1'b0);
    go(1'b0, 10'h07f);
    st(4'h5, 4'h0, 4'h0, 2'h0, 1'b1, 1'b1, 1'b0);
    go(1'b1, 10'h000);
    st(4'h5, 4'h0, 4'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    go(1'b1, 10'h07a);
    st(4'h5, 4'h0, 4'h0, 2'h0, 1'b1, 1'b0, 1'b0);
    go(1'b0, 10'h07a);
    st(4'ha, 4'h0, 4'h0, 2'h0, 1'b1, 1'b0, 1'b0);
    go(1'b1, 10'h073);
    go(1'b0, 10'h000);
    st(4'ha, 4'h0, 4'h0, 2'h0, 1'b1, 1'b1, 1'b0);
    $display("Accumulator load test done");
  endtask

  task automatic t_pair();
    go(1'b1, 10'h3c4);
    go(1'b1, 10'h3ff);
    st(4'ha, 4'hc, 4'h4, 2'h0, 1'b1, 1'b0, 1'b0);
    go(1'b1, 10'h070);
    st(4'ha, 4'hc, 4'h4, 2'h0, 1'b1, 1'b1, 1'b0);
    go(1'b1, 10'h3ff);
    st(4'h0, 4'hc, 4'h4, 2'h0, 1'b1, 1'b0, 1'b0);
    go(1'b0, 10'h000);
    st(4'h0, 4'hf, 4'hf, 2'h0, 1'b1, 1'b0, 1'b0);
    go(1'b1, 10'h3a5);
    go(1'b0, 10'h000);
    st(4'h0, 4'hf, 4'hf, 2'h0, 1'b1, 1'b1, 1'b0);
    $display("Pointer pair load test done");
  endtask

  task automatic t_bank();
    for (int i = 0; i < 4; i++) begin
      go(1'b1, 10'h048 | 10'(i));
      if (i > 0) begin
        st(4'h0, 4'hf, 4'hf, 2'(i - 1), 1'b1, 1'b0, 1'b0);
      end
    end
    go(1'b0, 10'h000);
    st(4'h0, 4'hf, 4'hf, 2'h3, 1'b1, 1'b0, 1'b0);
    $display("Bank pointer load test done");
  endtask

  task automatic t_carry();
    @(posedge clk);
    carry_we <= 1'b1;
    carry_din <= 1'b1;
    @(posedge clk);
    carry_we <= 1'b0;
    carry_din <= 1'b0;
    go(1'b1, 10'h075);
    go(1'b1, 10'h000);
    st(4'h5, 4'hf, 4'hf, 2'h3, 1'b1, 1'b0, 1'b0);
    chk({15'h0000, carry_flag}, 16'h0001);
    go(1'b0, 10'h000);
    st(4'h5, 4'hf, 4'hf, 2'h3, 1'b1, 1'b0, 1'b0);
    chk({15'h0000, carry_flag}, 16'h0001);
    $display("Carry test done");
  endtask

  task automatic t_foreign();
    go(1'b1, 10'h077);
    go(1'b1, 10'h200);
    st(4'h7, 4'hf, 4'hf, 2'h3, 1'b1, 1'b0, 1'b0);
    go(1'b1, 10'h076);
    st(4'h7, 4'hf, 4'hf, 2'h3, 1'b0, 1'b0, 1'b1);
    go(1'b0, 10'h000);
    st(4'h6, 4'hf, 4'hf, 2'h3, 1'b1, 1'b0, 1'b0);
    $display("Foreign opcode test done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    st(4'h0, 4'h0, 4'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    $display("Reset test done");
    t_acc();
    t_pair();
    t_bank();
    t_carry();
    t_foreign();
    test_done();
  end
endmodule
